//--- cut_cfg.svh
`ifndef CUT_CFG_SVH
`define CUT_CFG_SVH

// register indices, byte address is four times the index
`define CUT_IDX_MODE      16'h631a
`define CUT_IDX_PRE_LO    16'h631b
`define CUT_IDX_RLD_HI    16'h631c
`define CUT_IDX_RLD_LO    16'h631d
`define CUT_IDX_CNT_HI    16'h631e
`define CUT_IDX_CNT_LO    16'h631f
`define CUT_IDX_CTRL      16'h6320
`define CUT_IDX_STAT      16'h6330
`define CUT_IDX_MASK      16'h6331

// mode register fields
`define CUT_MODE_AUTO     7
`define CUT_MODE_GATE_MSB 6
`define CUT_MODE_GATE_LSB 5
`define CUT_MODE_RESTART  4
`define CUT_MODE_PRE_MSB  3
`define CUT_MODE_PRE_LSB  0

// control register fields, write one to act
`define CUT_CTRL_START    0
`define CUT_CTRL_STOP     1

// status register fields
`define CUT_STAT_IRQ      0
`define CUT_STAT_RUN      1
`define CUT_STAT_STICKY   8'h01

// reset values
`define CUT_RST_MODE      8'h00
`define CUT_RST_PRE_LO    8'h00
`define CUT_RST_RLD_HI    8'h00
`define CUT_RST_RLD_LO    8'h00
`define CUT_RST_MASK      8'h00

// clock rates in kHz
`define CUT_CLK_KHZ       250000
`define CUT_BASE_KHZ      6780

`endif

//--- cut_gate_sync.sv
`timescale 1ns/10ps
`default_nettype none

module cut_gate_sync
    import cut_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // pins
    input  wire logic signalInPin,
    input  wire logic auxOnePin,
    // gate link
    cut_tick_if.gate  tl
);

    logic [1:0] sigSyncQ;
    logic [1:0] auxSyncQ;
    logic       gateQ;

    // two-stage synchronisers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sigSyncQ <= 2'b00;
            auxSyncQ <= 2'b00;
        end else begin
            sigSyncQ <= {sigSyncQ[0], signalInPin};
            auxSyncQ <= {auxSyncQ[0], auxOnePin};
        end
    end

    // gate source select, reserved acts as no gating
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            gateQ <= 1'b1;
        end else begin
            case (tl.gateSel)
                CUT_GATE_NONE:   gateQ <= 1'b1;
                CUT_GATE_SIG_IN: gateQ <= sigSyncQ[1];
                CUT_GATE_AUX:    gateQ <= auxSyncQ[1];
                default:         gateQ <= 1'b1;
            endcase
        end
    end

    assign tl.gateOpen = gateQ;

endmodule

`default_nettype wire

//--- cut_pkg.sv
`default_nettype none

package cut_pkg;

    typedef enum logic [1:0] {
        CUT_IDLE = 2'b00,
        CUT_RUN  = 2'b01
    } cut_state_t;

    typedef enum logic [1:0] {
        CUT_GATE_NONE   = 2'b00,
        CUT_GATE_SIG_IN = 2'b01,
        CUT_GATE_AUX    = 2'b10,
        CUT_GATE_RSVD   = 2'b11
    } cut_gate_t;

endpackage

`default_nettype wire

//--- cut_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "cut_cfg.svh"

module cut_prescaler
    import cut_pkg::*;
#(
    parameter int CLK_KHZ  = `CUT_CLK_KHZ,
    parameter int BASE_KHZ = `CUT_BASE_KHZ
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // tick link
    cut_tick_if.pre   tl
);

    localparam logic [17:0] STEP = 18'(BASE_KHZ);
    localparam logic [17:0] MODV = 18'(CLK_KHZ);

    logic [17:0] accQ;
    logic [17:0] accSum;
    logic        baseTick;
    logic [11:0] divQ;
    logic [11:0] divLast;
    logic        tickQ;

    // fractional base tick from the system clock
    assign accSum   = accQ + STEP;
    assign baseTick = (accSum >= MODV);
    // divide value zero is taken as one
    assign divLast  = (tl.prescale == 12'h000) ? 12'h000 : tl.prescale - 12'h001;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            accQ <= 18'h00000;
        end else if (baseTick) begin
            accQ <= accSum - MODV;
        end else begin
            accQ <= accSum;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            divQ  <= 12'h000;
            tickQ <= 1'b0;
        end else if (tl.restart) begin
            divQ  <= 12'h000;
            tickQ <= 1'b0;
        end else if (baseTick) begin
            if (divQ >= divLast) begin
                divQ  <= 12'h000;
                tickQ <= 1'b1;
            end else begin
                divQ  <= divQ + 12'h001;
                tickQ <= 1'b0;
            end
        end else begin
            tickQ <= 1'b0;
        end
    end

    assign tl.tick = tickQ;

endmodule

`default_nettype wire

//--- cut_tick_if.sv
`timescale 1ns/10ps
`default_nettype none

interface cut_tick_if;
    import cut_pkg::*;
    logic [11:0] prescale;
    logic        restart;
    logic        tick;
    cut_gate_t   gateSel;
    logic        gateOpen;

    modport pre  (input prescale, input restart, output tick);
    modport gate (input gateSel, output gateOpen);
    modport core (output prescale, output restart, output gateSel,
                  input tick, input gateOpen);
endinterface

`default_nettype wire

//--- cut_timer.sv
// Functional notes
// - restart mode reloads and continues at zero
// - one-shot mode stops at zero, sets flag
// - tick equals base clock over prescaler
// - prescaler: mode nibble over prescaler byte
// - reload word sixteen bits, high byte register
// - autostart on end of transmission
// - start loads reload word, changes wait
// - running flag ignores gate level
`timescale 1ns/10ps
`default_nettype none
`include "cut_cfg.svh"

module cut_timer
    import cut_pkg::*;
#(
    parameter int AW       = 20,
    parameter int CLK_KHZ  = `CUT_CLK_KHZ,
    parameter int BASE_KHZ = `CUT_BASE_KHZ
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_b,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    // gate pins
    input  wire logic          signalInPin,
    input  wire logic          auxOnePin,
    // protocol engine
    input  wire logic          txEnd,
    // status outputs
    output var  logic          irq,
    output var  logic          timerRunning
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    cut_tick_if tl ();

    logic [7:0]  modeQ;
    logic [7:0]  preLoQ;
    logic [7:0]  rldHiQ;
    logic [7:0]  rldLoQ;
    logic [7:0]  maskQ;
    logic [7:0]  statusQ;
    logic [15:0] cntQ;
    cut_state_t  stateQ;
    logic        preadyQ;
    logic [31:0] prdataQ;
    logic        pslverrQ;
    logic        irqQ;
    logic        runQ;

    logic        access;
    logic        done;
    logic        hit;
    logic [7:0]  rdByte;
    logic        selMode;
    logic        selPreLo;
    logic        selRldHi;
    logic        selRldLo;
    logic        selCtrl;
    logic        selStat;
    logic        selMask;
    logic        wrMode;
    logic        wrPreLo;
    logic        wrRldHi;
    logic        wrRldLo;
    logic        wrCtrl;
    logic        wrMask;
    logic        startCmd;
    logic        stopCmd;
    logic        startEv;
    logic        countStep;
    logic        zeroEv;
    logic [15:0] reloadWord;
    logic [7:0]  statClr;
    logic [7:0]  statusD;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic addrIs(input logic [AW-1:0] a, input logic [15:0] idx);
        logic [AW-1:0] want;
        want = AW'({idx, 2'b00});
        return (a == want);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // submodules

    cut_prescaler #(
        .CLK_KHZ  (CLK_KHZ),
        .BASE_KHZ (BASE_KHZ)
    ) uPre (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .tl      (tl)
    );

    cut_gate_sync uGate (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .signalInPin (signalInPin),
        .auxOnePin   (auxOnePin),
        .tl          (tl)
    );

    assign tl.prescale = {modeQ[`CUT_MODE_PRE_MSB:`CUT_MODE_PRE_LSB], preLoQ};
    assign tl.gateSel  = cut_gate_t'(modeQ[`CUT_MODE_GATE_MSB:`CUT_MODE_GATE_LSB]);
    assign tl.restart  = startEv;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    assign access = psel & penable;
    assign done   = access & preadyQ;

    always_comb begin
        selMode  = 1'b0;
        selPreLo = 1'b0;
        selRldHi = 1'b0;
        selRldLo = 1'b0;
        selCtrl  = 1'b0;
        selStat  = 1'b0;
        selMask  = 1'b0;
        hit      = 1'b1;
        rdByte   = 8'h00;
        if (addrIs(paddr, `CUT_IDX_MODE)) begin
            selMode = 1'b1;
            rdByte  = modeQ;
        end else if (addrIs(paddr, `CUT_IDX_PRE_LO)) begin
            selPreLo = 1'b1;
            rdByte   = preLoQ;
        end else if (addrIs(paddr, `CUT_IDX_RLD_HI)) begin
            selRldHi = 1'b1;
            rdByte   = rldHiQ;
        end else if (addrIs(paddr, `CUT_IDX_RLD_LO)) begin
            selRldLo = 1'b1;
            rdByte   = rldLoQ;
        end else if (addrIs(paddr, `CUT_IDX_CNT_HI)) begin
            rdByte = cntQ[15:8];
        end else if (addrIs(paddr, `CUT_IDX_CNT_LO)) begin
            rdByte = cntQ[7:0];
        end else if (addrIs(paddr, `CUT_IDX_CTRL)) begin
            selCtrl = 1'b1;
        end else if (addrIs(paddr, `CUT_IDX_STAT)) begin
            selStat = 1'b1;
            rdByte  = statusQ;
            rdByte[`CUT_STAT_RUN] = runQ;
        end else if (addrIs(paddr, `CUT_IDX_MASK)) begin
            selMask = 1'b1;
            rdByte  = maskQ;
        end else begin
            hit = 1'b0;
        end
    end

    assign wrMode  = done & pwrite & selMode;
    assign wrPreLo = done & pwrite & selPreLo;
    assign wrRldHi = done & pwrite & selRldHi;
    assign wrRldLo = done & pwrite & selRldLo;
    assign wrCtrl  = done & pwrite & selCtrl;
    assign wrMask  = done & pwrite & selMask;

    ////////////////////////////////////////////////////////////////////////////
    // apb answer, one wait state

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            preadyQ  <= 1'b0;
            prdataQ  <= 32'h0000_0000;
            pslverrQ <= 1'b0;
        end else if (access & ~preadyQ) begin
            preadyQ  <= 1'b1;
            prdataQ  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
            pslverrQ <= ~hit;
        end else begin
            preadyQ  <= 1'b0;
            pslverrQ <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            modeQ  <= `CUT_RST_MODE;
            preLoQ <= `CUT_RST_PRE_LO;
            rldHiQ <= `CUT_RST_RLD_HI;
            rldLoQ <= `CUT_RST_RLD_LO;
            maskQ  <= `CUT_RST_MASK;
        end else begin
            if (wrMode) begin
                modeQ <= pwdata[7:0];
            end
            if (wrPreLo) begin
                preLoQ <= pwdata[7:0];
            end
            if (wrRldHi) begin
                rldHiQ <= pwdata[7:0];
            end
            if (wrRldLo) begin
                rldLoQ <= pwdata[7:0];
            end
            if (wrMask) begin
                maskQ <= pwdata[7:0] & `CUT_STAT_STICKY;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start, stop and count

    assign reloadWord = {rldHiQ, rldLoQ};
    assign startCmd   = wrCtrl & pwdata[`CUT_CTRL_START];
    assign stopCmd    = wrCtrl & pwdata[`CUT_CTRL_STOP];
    assign startEv    = ~stopCmd & (startCmd | (modeQ[`CUT_MODE_AUTO] & txEnd));
    assign countStep  = (stateQ == CUT_RUN) & tl.tick & tl.gateOpen & ~startEv & ~stopCmd;
    assign zeroEv     = countStep & (cntQ == 16'h0000);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stateQ <= CUT_IDLE;
            cntQ   <= 16'h0000;
        end else begin
            case (stateQ)
                CUT_IDLE: begin
                    if (startEv) begin
                        cntQ   <= reloadWord;
                        stateQ <= CUT_RUN;
                    end
                end
                CUT_RUN: begin
                    if (stopCmd) begin
                        stateQ <= CUT_IDLE;
                    end else if (startEv) begin
                        cntQ <= reloadWord;
                    end else if (zeroEv) begin
                        if (modeQ[`CUT_MODE_RESTART]) begin
                            cntQ <= reloadWord;
                        end else begin
                            stateQ <= CUT_IDLE;
                        end
                    end else if (countStep) begin
                        cntQ <= cntQ - 16'h0001;
                    end
                end
                default: begin
                    stateQ <= CUT_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status and interrupt

    // clear only what the read returned, a new event wins
    assign statClr = (done & ~pwrite & selStat) ? (prdataQ[7:0] & `CUT_STAT_STICKY) : 8'h00;

    always_comb begin
        statusD = statusQ & ~statClr;
        if (zeroEv) begin
            statusD[`CUT_STAT_IRQ] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            statusQ <= 8'h00;
            irqQ    <= 1'b0;
            runQ    <= 1'b0;
        end else begin
            statusQ <= statusD;
            irqQ    <= |(statusQ & maskQ);
            runQ    <= (stateQ == CUT_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata       = prdataQ;
    assign pready       = preadyQ;
    assign pslverr      = pslverrQ;
    assign irq          = irqQ;
    assign timerRunning = runQ;

endmodule

`default_nettype wire

//--- cut_timer_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "cut_cfg.svh"

module cut_timer_chk
    import cut_pkg::*;
#(
    parameter int AW = 20
) (
    // clock and reset
    input wire logic          ref_clk,
    input wire logic          rst_b,
    // apb
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    // pins and status
    input wire logic          signalInPin,
    input wire logic          auxOnePin,
    input wire logic          txEnd,
    input wire logic          irq,
    input wire logic          timerRunning
);
    logic wrDone;
    logic ctrlWr;
    logic autoQ;
    logic restartQ;
    logic maskQ;

    assign wrDone = psel && penable && pready && pwrite;
    assign ctrlWr = wrDone && paddr == AW'(`CUT_IDX_CTRL * 4);

    // shadow of mode and mask bits
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            autoQ    <= 1'b0;
            restartQ <= 1'b0;
        end else if (wrDone && paddr == AW'(`CUT_IDX_MODE * 4)) begin
            autoQ    <= pwdata[`CUT_MODE_AUTO];
            restartQ <= pwdata[`CUT_MODE_RESTART];
        end
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            maskQ <= 1'b0;
        end else if (wrDone && paddr == AW'(`CUT_IDX_MASK * 4)) begin
            maskQ <= pwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence apbSetup;
        psel && !penable;
    endsequence
    sequence apbAccess;
        psel && penable && !pready;
    endsequence

    chk_ready_wait: assert property (apbSetup ##1 apbAccess |=> pready)
        else $error("pready missing on second access edge");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_start_runs: assert property (ctrlWr && pwdata[0] && !pwdata[1] |-> ##[1:3] timerRunning)
        else $error("start write did not run timer");
    chk_stop_halts: assert property (ctrlWr && pwdata[1] |-> ##[1:3] !timerRunning)
        else $error("stop write did not halt timer");
    chk_auto_start: assert property (txEnd && autoQ |-> ##[1:3] timerRunning)
        else $error("end of transmission did not start timer");
    chk_oneshot_stop: assert property ($rose(irq) && !restartQ |-> ##[0:2] !timerRunning)
        else $error("one-shot timer still running at zero");
    chk_restart_runs: assert property ($rose(irq) && restartQ |-> timerRunning)
        else $error("restart timer stopped at zero");
    chk_irq_masked: assert property ((!maskQ)[*3] |-> !irq)
        else $error("irq high while masked");
endmodule

`default_nettype wire

//--- tb_contactless_unit_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "cut_cfg.svh"

module tb_contactless_unit_timer
    import cut_pkg::*;
;
    logic        ref_clk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [19:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        signalInPin;
    logic        auxOnePin;
    logic        txEnd;
    logic        irq;
    logic        timerRunning;
    logic [31:0] rd;
    logic        slvErr;
    int          errCount;
    int          nCompared;
    int          cyc = 0;
    int          t0;
    int          expT;
    logic [15:0] idxList [6] = '{`CUT_IDX_MODE, `CUT_IDX_PRE_LO, `CUT_IDX_RLD_HI,
                                 `CUT_IDX_RLD_LO, `CUT_IDX_MASK, `CUT_IDX_STAT};

    cut_timer #(.AW(20)) uut (
        .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .signalInPin(signalInPin),
        .auxOnePin(auxOnePin), .txEnd(txEnd), .irq(irq), .timerRunning(timerRunning)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        rd      = prdata;
        slvErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd);
    endtask

    task automatic rd_chk(input string what, input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(what, rd, {24'h0, exp});
    endtask

    task automatic wait_irq();
        for (int n = 0; n < 20000 && irq !== 1'b1; n++)
            @(posedge ref_clk);
    endtask

    task automatic completeRun();
        if (errCount == 0 && nCompared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        errCount++;
        completeRun();
    end

    ////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        signalInPin = 1'b0;
        auxOnePin = 1'b0;
        txEnd = 1'b0;
        errCount = 0;
        nCompared = 0;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        // reset values, access, unmapped
        foreach (idxList[i])
            rd_chk("reset value", idxList[i], 8'h00);
        wr(`CUT_IDX_PRE_LO, 8'ha5);
        wr(`CUT_IDX_RLD_HI, 8'h5a);
        rd_chk("prescale low", `CUT_IDX_PRE_LO, 8'ha5);
        rd_chk("reload high", `CUT_IDX_RLD_HI, 8'h5a);
        apb(1'b1, 16'h6321, 8'hff);
        check("unmapped err", slvErr, 1);
        rd_chk("unmapped read", 16'h6321, 8'h00);
        // one-shot, prescale 0x100 from nibble, reload 1
        wr(`CUT_IDX_MASK, 8'h01);
        wr(`CUT_IDX_MODE, 8'h01);
        wr(`CUT_IDX_PRE_LO, 8'h00);
        wr(`CUT_IDX_RLD_HI, 8'h00);
        wr(`CUT_IDX_RLD_LO, 8'h01);
        wr(`CUT_IDX_CTRL, 8'h01);
        t0 = cyc;
        wait_irq();
        expT = 2 * 256 * `CUT_CLK_KHZ / `CUT_BASE_KHZ;
        check("one-shot time", (cyc - t0 > expT - 40) && (cyc - t0 < expT + 40), 1);
        check("one-shot stop", timerRunning, 0);
        rd_chk("flag set", `CUT_IDX_STAT, 8'h01);
        rd_chk("flag cleared", `CUT_IDX_STAT, 8'h00);
        check("irq cleared", irq, 0);
        // restart mode, prescale 1, reload 2
        wr(`CUT_IDX_MODE, 8'h10);
        wr(`CUT_IDX_PRE_LO, 8'h01);
        wr(`CUT_IDX_RLD_LO, 8'h02);
        wr(`CUT_IDX_CTRL, 8'h01);
        wait_irq();
        t0 = cyc;
        rd_chk("restart status", `CUT_IDX_STAT, 8'h03);
        wr(`CUT_IDX_RLD_HI, 8'h01);
        wait_irq();
        expT = 3 * `CUT_CLK_KHZ / `CUT_BASE_KHZ;
        check("restart period", (cyc - t0 > expT - 6) && (cyc - t0 < expT + 6), 1);
        wr(`CUT_IDX_CTRL, 8'h01);
        rd_chk("new reload", `CUT_IDX_CNT_HI, 8'h01);
        wr(`CUT_IDX_CTRL, 8'h02);
        rd_chk("stopped", `CUT_IDX_STAT, 8'h01);
        // start on end of transmission
        for (int a = 0; a < 2; a++) begin
            wr(`CUT_IDX_MODE, a ? 8'h80 : 8'h00);
            @(posedge ref_clk);
            txEnd <= 1'b1;
            @(posedge ref_clk);
            txEnd <= 1'b0;
            repeat (3) @(posedge ref_clk);
            check("autostart", timerRunning, a);
            wr(`CUT_IDX_CTRL, 8'h02);
        end
        // gate codes, wrong pin high first
        for (int g = 0; g < 4; g++) begin
            signalInPin <= (g == 2);
            auxOnePin <= (g == 1);
            wr(`CUT_IDX_MODE, 8'(g << 5));
            wr(`CUT_IDX_CTRL, 8'h01);
            repeat (300) @(posedge ref_clk);
            check("running gated", timerRunning, 1);
            apb(1'b0, `CUT_IDX_CNT_LO, 8'h00);
            check("gate hold", rd == 32'h02, g == 1 || g == 2);
            signalInPin <= (g == 1);
            auxOnePin <= (g == 2);
            repeat (300) @(posedge ref_clk);
            apb(1'b0, `CUT_IDX_CNT_LO, 8'h00);
            check("gate open", rd == 32'h02, 0);
            wr(`CUT_IDX_CTRL, 8'h02);
        end
        // stop wins over start, masked flag keeps irq low
        wr(`CUT_IDX_MASK, 8'h00);
        wr(`CUT_IDX_RLD_HI, 8'h00);
        wr(`CUT_IDX_MODE, 8'h00);
        wr(`CUT_IDX_CTRL, 8'h03);
        rd_chk("stop wins", `CUT_IDX_STAT, 8'h00);
        wr(`CUT_IDX_CTRL, 8'h01);
        repeat (200) @(posedge ref_clk);
        check("masked irq", irq, 0);
        rd_chk("masked flag", `CUT_IDX_STAT, 8'h01);
        completeRun();
    end
endmodule

bind cut_timer cut_timer_chk #(.AW(AW)) chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .signalInPin(signalInPin),
    .auxOnePin(auxOnePin), .txEnd(txEnd), .irq(irq), .timerRunning(timerRunning)
);

`default_nettype wire
